// ---- src/line_format_defs.svh ----
// Register offsets, field positions and reset values of the UART channel.
// Assumes a 32-bit AXI4-Lite slave decoding the low eight address bits.
`ifndef LINE_FORMAT_DEFS_SVH
`define LINE_FORMAT_DEFS_SVH

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define OFS_LINE_FORMAT   8'h00
`define OFS_DATA          8'h04
`define OFS_DIVISOR       8'h08
`define OFS_ENH_FEATURE   8'h0C
`define OFS_LINE_STATUS   8'h10
`define OFS_IRQ_STATUS    8'h14
`define OFS_IRQ_CLEAR     8'h18
`define OFS_IRQ_ENABLE    8'h1C

// ---------------------------------------------------------------------
// Reset values and field layout
// ---------------------------------------------------------------------
`define LINE_FORMAT_RESET 8'h00
`define DIVISOR_RESET     16'h0008
`define ENH_FEATURE_RESET 8'h00
`define IRQ_BIT_TX_DONE   0
`define IRQ_BIT_RX_DONE   1
`define IRQ_BIT_PARITY    2
`define IRQ_BIT_FRAMING   3
`define IRQ_WIDTH         4
`define HALVES_PER_BIT    3'd2
`define HALVES_STOP_ONE   3'd2
`define HALVES_STOP_HALF  3'd3
`define HALVES_STOP_TWO   3'd4
`define AXI_RESP_OKAY     2'b00
`define AXI_RESP_SLVERR   2'b10

`endif

// ---- src/line_format_pkg.sv ----
// Types shared by the UART channel: the format word and the serial states.
// Assumes the constants header is included by the design files.
package line_format_pkg;

  typedef struct packed {
    logic       divisor_access_enable;
    logic       break_force;
    logic       parity_force;
    logic       parity_even_select;
    logic       parity_enable;
    logic       stop_length_select;
    logic [1:0] char_length_select;
  } line_format_t;

  typedef enum logic [2:0] {
    SER_IDLE   = 3'b000,
    SER_START  = 3'b001,
    SER_DATA   = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP   = 3'b100
  } ser_state_t;

endpackage

// ---- src/uart_line_format_control.sv ----
// One UART channel with programmable character format behind an AXI4-Lite slave.
// Assumes one clock, an asynchronous active-high reset and RX synchronous to CLOCK.
`timescale 1ns/1ps
`include "line_format_defs.svh"

// What this block does
// - Divisor and enhanced feature registers reachable only while divisor access is set.
// - Break force holds the transmit output low until software clears it.
// - Parity enable off means no parity bit; on appends one after data.
// - With parity on, the receiver checks data and parity and flags errors.
// - Unforced parity: select 0 gives odd count of ones, 1 gives even.
// - Forced parity bit is 1 when select is 0, 0 when select is 1.
// - Stop length select 0 gives exactly one stop bit for every word length.
// - Stop length select 1 gives 1.5 stops for 5 bits, else two.
// - Length field codes 00 to 11 select 5 to 8 data bits.
// - Every line format bit is zero after reset.
module uart_line_format_control
  import line_format_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        RX,
  output logic             TX,
  output logic             IRQ
);

  // -------------------------------------------------------------------
  // Format helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] len_mask(input logic [1:0] code);
    logic [7:0] m;
    m = 8'hFF >> (2'd3 - code);
    return m;
  endfunction

  function automatic logic parity_of(input logic [7:0] data, input line_format_t f);
    logic ones;
    ones = ^(data & len_mask(f.char_length_select));
    if (f.parity_force) return ~f.parity_even_select;
    return f.parity_even_select ? ones : ~ones;
  endfunction

  function automatic logic [2:0] stop_halves(input line_format_t f);
    if (!f.stop_length_select) return `HALVES_STOP_ONE;
    if (f.char_length_select == 2'b00) return `HALVES_STOP_HALF;
    return `HALVES_STOP_TWO;
  endfunction

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  line_format_t               fmt_q;
  logic [15:0]                divisor_q;
  logic [7:0]                 enh_q;
  logic [`IRQ_WIDTH-1:0]      irq_sts_q;
  logic [`IRQ_WIDTH-1:0]      irq_en_q;
  logic [7:0]                 tx_hold_q;
  logic                       tx_pend_q;
  logic [7:0]                 rx_data_q;
  logic                       rx_ready_q;
  logic                       aw_have_q;
  logic                       w_have_q;
  logic [7:0]                 aw_addr_q;
  logic [31:0]                w_data_q;
  logic [3:0]                 w_strb_q;
  logic                       wr_fire;
  logic                       rd_fire;
  logic                       wr_mapped;
  logic                       rd_mapped;
  logic [31:0]                rd_word;
  logic                       tx_done;
  logic                       rx_done;
  logic                       rx_par_err;
  logic                       rx_frm_err;
  logic                       tx_start;
  ser_state_t                 tx_state_q;
  logic                       tx_tick;

  // -------------------------------------------------------------------
  // AXI4-Lite write channel
  // -------------------------------------------------------------------
  assign S_AXI_AWREADY = !aw_have_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_have_q && !S_AXI_BVALID;
  assign wr_fire       = aw_have_q && w_have_q && !S_AXI_BVALID;

  always_comb begin
    case (aw_addr_q)
      `OFS_LINE_FORMAT, `OFS_DATA, `OFS_DIVISOR, `OFS_ENH_FEATURE,
      `OFS_LINE_STATUS, `OFS_IRQ_STATUS, `OFS_IRQ_CLEAR, `OFS_IRQ_ENABLE: wr_mapped = 1'b1;
      default: wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= `AXI_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_have_q <= 1'b1;
        w_data_q <= S_AXI_WDATA;
        w_strb_q <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Gated registers ignore writes while divisor access is off, so a stray
  // write cannot retune the baud rate during normal traffic.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      fmt_q     <= `LINE_FORMAT_RESET;
      divisor_q <= `DIVISOR_RESET;
      enh_q     <= `ENH_FEATURE_RESET;
      irq_en_q  <= '0;
    end else if (wr_fire) begin
      if (aw_addr_q == `OFS_LINE_FORMAT && w_strb_q[0]) fmt_q <= w_data_q[7:0];
      if (aw_addr_q == `OFS_IRQ_ENABLE && w_strb_q[0]) irq_en_q <= w_data_q[`IRQ_WIDTH-1:0];
      if (fmt_q.divisor_access_enable) begin
        if (aw_addr_q == `OFS_DIVISOR && w_strb_q[0]) divisor_q[7:0] <= w_data_q[7:0];
        if (aw_addr_q == `OFS_DIVISOR && w_strb_q[1]) divisor_q[15:8] <= w_data_q[15:8];
        if (aw_addr_q == `OFS_ENH_FEATURE && w_strb_q[0]) enh_q <= w_data_q[7:0];
      end
    end
  end

  assign tx_start = (tx_state_q == SER_IDLE) && tx_pend_q && tx_tick;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end else if (wr_fire && aw_addr_q == `OFS_DATA && w_strb_q[0] && !tx_pend_q) begin
      tx_hold_q <= w_data_q[7:0];
      tx_pend_q <= 1'b1;
    end else if (tx_start) begin
      tx_pend_q <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // AXI4-Lite read channel
  // -------------------------------------------------------------------
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

  always_comb begin
    rd_word   = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (S_AXI_ARADDR)
      `OFS_LINE_FORMAT: rd_word[7:0] = fmt_q;
      `OFS_DATA:        rd_word[7:0] = rx_data_q;
      `OFS_DIVISOR:     rd_word[15:0] = fmt_q.divisor_access_enable ? divisor_q : 16'h0000;
      `OFS_ENH_FEATURE: rd_word[7:0] = fmt_q.divisor_access_enable ? enh_q : 8'h00;
      `OFS_LINE_STATUS: rd_word[3:0] = {tx_state_q != SER_IDLE, tx_pend_q, 1'b0, rx_ready_q};
      `OFS_IRQ_STATUS:  rd_word[`IRQ_WIDTH-1:0] = irq_sts_q;
      `OFS_IRQ_CLEAR:   rd_word = 32'h0000_0000;
      `OFS_IRQ_ENABLE:  rd_word[`IRQ_WIDTH-1:0] = irq_en_q;
      default:          rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= `AXI_RESP_OKAY;
    end else if (rd_fire) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rd_word;
      S_AXI_RRESP  <= rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Interrupts
  // -------------------------------------------------------------------
  logic [`IRQ_WIDTH-1:0] irq_set;
  logic [`IRQ_WIDTH-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[`IRQ_BIT_TX_DONE] = tx_done;
    irq_set[`IRQ_BIT_RX_DONE] = rx_done;
    irq_set[`IRQ_BIT_PARITY]  = rx_par_err;
    irq_set[`IRQ_BIT_FRAMING] = rx_frm_err;
    irq_clr = (wr_fire && aw_addr_q == `OFS_IRQ_CLEAR && w_strb_q[0]) ? w_data_q[`IRQ_WIDTH-1:0] : '0;
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) irq_sts_q <= '0;
    else     irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
  end

  assign IRQ = |(irq_sts_q & irq_en_q);

  // -------------------------------------------------------------------
  // Transmitter, paced in half-bit ticks of divisor cycles
  // -------------------------------------------------------------------
  line_format_t tx_fmt_q;
  logic [15:0]  tx_div_q;
  logic         tx_par_q;
  logic [2:0]   tx_halves_q;
  logic [2:0]   tx_bits_q;
  logic [7:0]   tx_sh_q;
  logic         tx_line_q;

  assign tx_tick = (tx_div_q == 16'h0000);
  assign tx_done = (tx_state_q == SER_STOP) && tx_tick && tx_halves_q == 3'd1;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) tx_div_q <= 16'h0000;
    else     tx_div_q <= tx_tick ? divisor_q - 16'h0001 : tx_div_q - 16'h0001;
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      tx_state_q  <= SER_IDLE;
      tx_fmt_q    <= `LINE_FORMAT_RESET;
      tx_halves_q <= 3'd0;
      tx_bits_q   <= 3'd0;
      tx_sh_q     <= 8'h00;
      tx_line_q   <= 1'b1;
      tx_par_q    <= 1'b0;
    end else if (tx_tick) begin
      tx_halves_q <= tx_halves_q - 3'd1;
      case (tx_state_q)
        SER_IDLE: if (tx_pend_q) begin
          tx_fmt_q    <= fmt_q;
          tx_sh_q     <= tx_hold_q;
          // Parity is fixed here, as the holding register may take the next byte mid-character.
          tx_par_q    <= parity_of(tx_hold_q, fmt_q);
          tx_line_q   <= 1'b0;
          tx_halves_q <= `HALVES_PER_BIT;
          tx_state_q  <= SER_START;
        end
        SER_START: if (tx_halves_q == 3'd1) begin
          tx_line_q   <= tx_sh_q[0];
          tx_bits_q   <= {1'b1, tx_fmt_q.char_length_select};
          tx_halves_q <= `HALVES_PER_BIT;
          tx_state_q  <= SER_DATA;
        end
        SER_DATA: if (tx_halves_q == 3'd1) begin
          tx_sh_q     <= {1'b0, tx_sh_q[7:1]};
          tx_bits_q   <= tx_bits_q - 3'd1;
          if (tx_bits_q != 3'd0) begin
            tx_line_q   <= tx_sh_q[1];
            tx_halves_q <= `HALVES_PER_BIT;
          end else if (tx_fmt_q.parity_enable) begin
            tx_line_q   <= tx_par_q;
            tx_halves_q <= `HALVES_PER_BIT;
            tx_state_q  <= SER_PARITY;
          end else begin
            tx_line_q   <= 1'b1;
            tx_halves_q <= stop_halves(tx_fmt_q);
            tx_state_q  <= SER_STOP;
          end
        end
        SER_PARITY: if (tx_halves_q == 3'd1) begin
          tx_line_q   <= 1'b1;
          tx_halves_q <= stop_halves(tx_fmt_q);
          tx_state_q  <= SER_STOP;
        end
        SER_STOP: if (tx_halves_q == 3'd1) tx_state_q <= SER_IDLE;
        default: tx_state_q <= SER_IDLE;
      endcase
    end
  end

  // Break overrides the line live, not per character, so it takes hold at once.
  assign TX = tx_line_q & ~fmt_q.break_force;

  // -------------------------------------------------------------------
  // Receiver; sampling falls at each bit centre
  // -------------------------------------------------------------------
  ser_state_t   rx_state_q;
  line_format_t rx_fmt_q;
  logic [15:0]  rx_div_q;
  logic         rx_tick;
  logic [2:0]   rx_halves_q;
  logic [2:0]   rx_bits_q;
  logic [7:0]   rx_sh_q;
  logic [7:0]   rx_word;
  logic         rx_par_bad_q;

  assign rx_tick = (rx_div_q == 16'h0000);
  assign rx_word = rx_sh_q >> (2'd3 - rx_fmt_q.char_length_select);
  assign rx_done = (rx_state_q == SER_STOP) && rx_tick && rx_halves_q == 3'd1;
  assign rx_frm_err = rx_done && !RX;
  assign rx_par_err = rx_done && rx_par_bad_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_state_q   <= SER_IDLE;
      rx_fmt_q     <= `LINE_FORMAT_RESET;
      rx_div_q     <= 16'h0000;
      rx_halves_q  <= 3'd0;
      rx_bits_q    <= 3'd0;
      rx_sh_q      <= 8'h00;
      rx_par_bad_q <= 1'b0;
    end else if (rx_state_q == SER_IDLE) begin
      if (!RX) begin
        rx_fmt_q     <= fmt_q;
        rx_div_q     <= divisor_q - 16'h0001;
        rx_par_bad_q <= 1'b0;
        rx_state_q   <= SER_START;
      end
    end else begin
      rx_div_q <= rx_tick ? divisor_q - 16'h0001 : rx_div_q - 16'h0001;
      if (rx_tick) begin
        rx_halves_q <= rx_halves_q - 3'd1;
        case (rx_state_q)
          SER_START: begin
            rx_halves_q <= `HALVES_PER_BIT;
            rx_bits_q   <= {1'b1, rx_fmt_q.char_length_select};
            // A start bit gone high by its centre was a glitch.
            rx_state_q  <= RX ? SER_IDLE : SER_DATA;
          end
          SER_DATA: if (rx_halves_q == 3'd1) begin
            rx_sh_q     <= {RX, rx_sh_q[7:1]};
            rx_bits_q   <= rx_bits_q - 3'd1;
            rx_halves_q <= `HALVES_PER_BIT;
            if (rx_bits_q == 3'd0)
              rx_state_q <= rx_fmt_q.parity_enable ? SER_PARITY : SER_STOP;
          end
          SER_PARITY: if (rx_halves_q == 3'd1) begin
            rx_par_bad_q <= RX != parity_of(rx_word, rx_fmt_q);
            rx_halves_q  <= `HALVES_PER_BIT;
            rx_state_q   <= SER_STOP;
          end
          SER_STOP: if (rx_halves_q == 3'd1) rx_state_q <= SER_IDLE;
          default: rx_state_q <= SER_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_data_q  <= 8'h00;
      rx_ready_q <= 1'b0;
    end else if (rx_done) begin
      rx_data_q  <= rx_word;
      rx_ready_q <= 1'b1;
    end else if (rd_fire && S_AXI_ARADDR == `OFS_DATA) begin
      rx_ready_q <= 1'b0;
    end
  end

endmodule // uart_line_format_control

// ---- verification/line_format_properties.sv ----
// Checker for the UART format block: bus answers, break hold and format readback.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module line_format_properties (
  input wire logic        CLOCK,
  input wire logic        RST,
  input wire logic [7:0]  S_AXI_AWADDR,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0]  S_AXI_WSTRB,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic        TX
);
  // ----
  // Shadow of the format register
  // ----
  // The shadow lags the register by one cycle, so the update cycle is excluded below.
  logic [7:0] aw_q, ar_q, wd_q, fmt_q;
  logic       st_q, bv_q, upd;
  assign upd = S_AXI_BVALID && !bv_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      aw_q <= 8'h00;
      ar_q <= 8'h00;
      wd_q <= 8'h00;
      st_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) aw_q <= S_AXI_AWADDR;
      if (S_AXI_ARVALID && S_AXI_ARREADY) ar_q <= S_AXI_ARADDR;
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wd_q <= S_AXI_WDATA[7:0];
        st_q <= S_AXI_WSTRB[0];
      end
    end
  end
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      bv_q  <= 1'b0;
      fmt_q <= 8'h00;
    end else begin
      bv_q <= S_AXI_BVALID;
      if (upd && aw_q == 8'h00 && st_q) fmt_q <= wd_q;
    end
  end
  // ----
  // Properties
  // ----
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_read_taken;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  sequence s_write_both;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  a_read_answer: assert property (s_read_taken |=> S_AXI_RVALID)
    else $error("read not answered one cycle after the address");
  a_write_answer: assert property (s_write_both |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
    else $error("write response not raised two cycles after the transfer");
  a_read_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped or changed while stalled");
  a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted while an answer stands");
  a_break_low: assert property (fmt_q[6] && !upd |-> !TX)
    else $error("transmit line high while break is set");
  a_format_read: assert property (S_AXI_RVALID && ar_q == 8'h00 |-> S_AXI_RDATA == {24'h0, fmt_q})
    else $error("format register read differs from written value");
  a_divisor_gated: assert property (S_AXI_RVALID && ar_q inside {8'h08, 8'h0C} && !fmt_q[7] |-> S_AXI_RDATA == 32'h0)
    else $error("gated register readable without divisor access");
  a_unmapped_err: assert property (S_AXI_RVALID && ar_q >= 8'h20 |-> S_AXI_RRESP == 2'b10)
    else $error("unmapped read not refused");
endmodule // line_format_properties

bind uart_line_format_control line_format_properties chk (.CLOCK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARADDR,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .TX);

// ---- verification/serial_peer.sv ----
// Remote serial peer: frames characters onto RX and decodes frames seen on TX.
// Assumes a bit time of two half-bit periods of HALF clock cycles.
`timescale 1ns/1ps
module serial_peer #(
  parameter int HALF = 8
) (
  input  wire logic clk,
  input  wire logic tx,
  output logic      rx
);
  int cyc = 0;
  always @(posedge clk) cyc <= cyc + 1;
  initial rx = 1'b1;
  // The caller chooses the parity bit, so a wrong one is sent only on purpose.
  task automatic send(input logic [7:0] d, input int n, input logic pen, input logic p);
    logic q[$];
    int   k;
    q = {1'b0};
    for (k = 0; k < n; k++) q.push_back(d[k]);
    if (pen) q.push_back(p);
    q.push_back(1'b1);
    foreach (q[j]) begin
      @(posedge clk) rx <= q[j];
      repeat (2 * HALF - 1) @(posedge clk);
    end
  endtask
  // Samples each bit at its centre; t0 marks the start edge for spacing checks.
  task automatic get(input int n, input logic pen, output logic [7:0] d, output logic p,
                     output logic stp, output int t0);
    int k;
    d = 8'h00;
    p = 1'b0;
    while (tx !== 1'b0) @(posedge clk);
    t0 = cyc;
    repeat (HALF) @(posedge clk);
    for (k = 0; k < n; k++) begin
      repeat (2 * HALF) @(posedge clk);
      d[k] = tx;
    end
    if (pen) begin
      repeat (2 * HALF) @(posedge clk);
      p = tx;
    end
    repeat (2 * HALF) @(posedge clk);
    stp = tx;
  endtask
endmodule // serial_peer

// ---- verification/tb_top.sv ----
// Self-checking bench for the UART format block with a remote serial peer.
// Assumes the register offsets of the constants header and reset divisor.
`timescale 1ns/1ps
`include "line_format_defs.svh"
module tb_top
  import line_format_pkg::*;
;
  localparam int       HALF = `DIVISOR_RESET;
  localparam logic [2:0] PM [5] = '{3'b000, 3'b001, 3'b011, 3'b101, 3'b111};
  logic        CLOCK = 1'b0, RST = 1'b1, RX;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB = 4'hF;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0, S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, TX, IRQ;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, resp;
  int          error_cnt = 0, checks_done = 0, cycles = 0;
  uart_line_format_control uut (.CLOCK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .RX, .TX, .IRQ);
  serial_peer #(.HALF(HALF)) peer (.clk(CLOCK), .tx(TX), .rx(RX));
  always #50 CLOCK = ~CLOCK;
  // ----
  // Bus tasks and checks
  // ----
  task automatic results();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do begin
      @(posedge CLOCK);
      if (aw && S_AXI_AWREADY) begin
        aw = 1'b0;
        S_AXI_AWVALID <= 1'b0;
      end
      if (w && S_AXI_WREADY) begin
        w = 1'b0;
        S_AXI_WVALID <= 1'b0;
      end
    end while (!S_AXI_BVALID);
    resp = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask
  // Ready is raised a cycle late on purpose, so a stalled answer is exercised.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge CLOCK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLOCK); while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b1;
    @(posedge CLOCK);
    d = S_AXI_RDATA;
    resp = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask
  function automatic logic parx(input logic [7:0] d, input line_format_t f);
    logic x;
    x = ^(d & ~(8'hFF << (5 + f.char_length_select)));
    if (f.parity_force) return ~f.parity_even_select;
    return f.parity_even_select ? x : ~x;
  endfunction
  function automatic int span(input line_format_t f);
    int n;
    n = 5 + f.char_length_select;
    return (1 + n + f.parity_enable) * 2 * HALF + HALF * (!f.stop_length_select ? 2 : (n == 5 ? 3 : 4));
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    line_format_t f;
    logic [31:0]  v;
    logic [7:0]   da, db, ga, gb, m;
    logic         pa, pb, sa, sb, bad;
    int           t0, t1, i;
    void'($urandom(74));
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    rd(`OFS_LINE_FORMAT, v);
    chk("format reset", 32'h0, v);
    wr(`OFS_DIVISOR, 32'h0003);
    rd(`OFS_DIVISOR, v);
    chk("gated divisor", 32'h0, v);
    wr(`OFS_LINE_FORMAT, 32'h80);
    wr(`OFS_ENH_FEATURE, 32'hA5);
    rd(`OFS_DIVISOR, v);
    chk("divisor", {16'h0, `DIVISOR_RESET}, v);
    rd(`OFS_ENH_FEATURE, v);
    chk("enhanced", 32'hA5, v);
    wr(`OFS_LINE_FORMAT, 32'h0);
    rd(`OFS_ENH_FEATURE, v);
    chk("gated enhanced", 32'h0, v);
    rd(8'h40, v);
    chk("unmapped resp", `AXI_RESP_SLVERR, resp);
    wr(8'h40, 32'h0);
    chk("unmapped write resp", `AXI_RESP_SLVERR, resp);
    wr(`OFS_IRQ_ENABLE, 32'h1);
    for (i = 0; i < 10; i++) begin
      v = $urandom;
      f = line_format_t'({2'b00, PM[i % 5], i[2], i[1:0]});
      m = 8'hFF >> (3 - i % 4);
      da = v[7:0];
      db = v[15:8];
      bad = f.parity_enable & v[16];
      wr(`OFS_LINE_FORMAT, {24'h0, f});
      rd(`OFS_LINE_FORMAT, v);
      chk("format readback", {24'h0, f}, v);
      fork
        begin
          peer.get(5 + i % 4, f.parity_enable, ga, pa, sa, t0);
          peer.get(5 + i % 4, f.parity_enable, gb, pb, sb, t1);
        end
        begin
          wr(`OFS_DATA, {24'h0, da});
          do rd(`OFS_LINE_STATUS, v); while (v[2]);
          wr(`OFS_DATA, {24'h0, db});
        end
      join
      chk("tx data", da & m, ga);
      chk("tx data", db & m, gb);
      chk("tx parity", f.parity_enable ? parx(da, f) : 1'b0, pa);
      chk("tx parity", f.parity_enable ? parx(db, f) : 1'b0, pb);
      chk("stop level", 1'b1, sa);
      chk("frame spacing", span(f), (t1 - t0 >= span(f) && t1 - t0 <= span(f) + HALF) ? span(f) : t1 - t0);
      peer.send(da, 5 + i % 4, f.parity_enable, parx(da, f) ^ bad);
      repeat (2 * HALF) @(posedge CLOCK);
      rd(`OFS_DATA, v);
      chk("rx data", da & m, v);
      rd(`OFS_IRQ_STATUS, v);
      chk("parity error", bad, v[2]);
      chk("framing error", 1'b0, v[3]);
      chk("irq raised", 1'b1, IRQ);
      wr(`OFS_IRQ_ENABLE, 32'h0);
      chk("irq masked", 1'b0, IRQ);
      wr(`OFS_IRQ_CLEAR, 32'hF);
      wr(`OFS_IRQ_ENABLE, 32'h1);
      chk("irq cleared", 1'b0, IRQ);
    end
    wr(`OFS_LINE_FORMAT, 32'h43);
    wr(`OFS_DATA, 32'hFF);
    repeat (3 * HALF) begin
      @(posedge CLOCK);
      chk("break line", 1'b0, TX);
    end
    wr(`OFS_LINE_FORMAT, 32'h03);
    repeat (24 * HALF) @(posedge CLOCK);
    chk("line released", 1'b1, TX);
    results();
  end
endmodule // tb_top
